// ===== dv/clock_switch_sleep_tb_top.sv
// Self-checking bench for the clock switch and sleep controller
`timescale 1ns/1ps
`default_nettype none
module clock_switch_sleep_tb_top;
    // Bench signals carry the port names so the instance can connect them by name
    logic SYS_CLK_IN = 0, RESETN_IN = 0, S_AXI_AWVALID_IN = 0, S_AXI_WVALID_IN = 0;
    logic S_AXI_BREADY_IN = 1, S_AXI_ARVALID_IN = 0, S_AXI_RREADY_IN = 1, CLK_OUT_FUSE_IN = 0;
    logic SLEEP_INSTR_IN = 0, ADC_ENABLED_IN = 1, ADC_DONE_IN = 0, WAKE_IRQ_IN = 0;
    logic WAKE_LIMITED_IN = 0, WAKE_DEEP_IN = 0, WAKE_TIMER_IN = 0, RESET_WAKE_IN = 0;
    logic [7:0] S_AXI_AWADDR_IN = 8'h00, S_AXI_ARADDR_IN = 8'h00, rd;
    logic [31:0] S_AXI_WDATA_IN = 32'h0, S_AXI_RDATA_OUT;
    logic [3:0] S_AXI_WSTRB_IN = 4'hF, SOURCE_FUSE_IN = 4'h2, CMD_CODE_OUT, CMD_SOURCE_OUT;
    logic [3:0] SYS_SOURCE_OUT;
    logic [1:0] STARTUP_FUSE_IN = 2'h1, S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, CMD_STARTUP_OUT, rsp;
    logic [15:0] CLK_STABLE_IN = 16'hFFFF, SRC_ENABLE_OUT;
    logic S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT;
    logic S_AXI_RVALID_OUT, CMD_STROBE_OUT, CLK_PIN_EN_OUT, WDT_AUTO_RELOAD_OUT;
    logic BROWNOUT_EN_OUT, ADC_START_OUT, SLEEPING_OUT, RESUME_OUT, RESET_VECTOR_OUT;
    clksw_pkg::clk_gates_type CLK_GATES_OUT;
    int fails = 0, n_checks = 0;
    // Short brown-out wake keeps the run brief
    clock_switch_sleep #(.BOD_WAKE_CYCLES(12)) u_clock_switch_sleep (.*);
    initial begin
        forever #5 SYS_CLK_IN = ~SYS_CLK_IN;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // Bus tasks are entered at a rising edge; AW and W go out together
    task wr(input logic [7:0] a, input logic [7:0] d);
        S_AXI_AWADDR_IN <= a;
        S_AXI_WDATA_IN <= {24'h0, d};
        S_AXI_AWVALID_IN <= 1'b1;
        S_AXI_WVALID_IN <= 1'b1;
        do begin
            @(posedge SYS_CLK_IN);
            if (S_AXI_AWREADY_OUT === 1'b1) S_AXI_AWVALID_IN <= 1'b0;
            if (S_AXI_WREADY_OUT === 1'b1) S_AXI_WVALID_IN <= 1'b0;
        end while (S_AXI_BVALID_OUT !== 1'b1);
        rsp = S_AXI_BRESP_OUT;
    endtask
    task rdr(input logic [7:0] a);
        S_AXI_ARADDR_IN <= a;
        S_AXI_ARVALID_IN <= 1'b1;
        do begin
            @(posedge SYS_CLK_IN);
            if (S_AXI_ARREADY_OUT === 1'b1) S_AXI_ARVALID_IN <= 1'b0;
        end while (S_AXI_RVALID_OUT !== 1'b1);
        rd = S_AXI_RDATA_OUT[7:0];
        rsp = S_AXI_RRESP_OUT;
    endtask
    task t_regs;
        rdr(8'h04);
        chk(rd, 8'h52);
        rdr(8'h00);
        chk(rd & 8'hE0, 8'h00);
        rdr(8'h0C);
        chk(rd[6], 1'b0);
        rdr(8'h14);
        chk(rsp, 2'h2);
        $display("regs done");
    endtask
    // Codes 0010 to 1000 once each; 1xxx must leave the last command in place
    task t_cmds;
        for (int i = 2; i < 9; i++) begin
            wr(8'h00, 8'h80);
            wr(8'h00, i[7:0]);
            chk(CMD_STROBE_OUT, i < 8);
            @(posedge SYS_CLK_IN);
            chk(CMD_CODE_OUT, (i == 8) ? 4'h7 : i[3:0]);
        end
        chk({CLK_PIN_EN_OUT, WDT_AUTO_RELOAD_OUT, CMD_SOURCE_OUT}, 6'h32);
        wr(8'h00, 8'h80);
        rdr(8'h00);
        chk(rd[7], 1'b1);
        wr(8'h00, 8'h81);
        wr(8'h00, 8'h03);
        @(posedge SYS_CLK_IN);
        chk(CMD_CODE_OUT, 4'h7);
        // Second arm lands late in the window; a restart would let the command in
        wr(8'h00, 8'h80);
        wr(8'h00, 8'h80);
        wr(8'h00, 8'h03);
        @(posedge SYS_CLK_IN);
        chk(CMD_CODE_OUT, 4'h7);
        $display("cmds done");
    endtask
    // Enter a light sleep, wake it, and time the stall to the resume pulse
    task t_sleep(input logic [1:0] m, input logic [4:0] g);
        int n;
        wr(8'h08, {5'h0, m, 1'b1});
        SLEEP_INSTR_IN <= 1'b1;
        @(posedge SYS_CLK_IN);
        SLEEP_INSTR_IN <= 1'b0;
        #1;
        chk({SLEEPING_OUT, ADC_START_OUT, CLK_GATES_OUT}, {2'h3, g});
        @(posedge SYS_CLK_IN);
        if (m == 2'h1) ADC_DONE_IN <= 1'b1;
        else WAKE_IRQ_IN <= 1'b1;
        n = 0;
        do begin
            @(posedge SYS_CLK_IN);
            ADC_DONE_IN <= 1'b0;
            WAKE_IRQ_IN <= 1'b0;
            n++;
            #1;
        end while (RESUME_OUT !== 1'b1 && n < 20);
        // Wake edge counts one, then four stall cycles
        chk(n, 5);
        chk(CLK_GATES_OUT, 5'h1F);
        @(posedge SYS_CLK_IN);
        $display("sleep mode %0d done", m);
    endtask
    // Hand the system clock to a second source, then retire the first
    task t_switch;
        int n;
        wr(8'h04, 8'h53);
        wr(8'h00, 8'h80);
        wr(8'h00, 8'h02);
        n = 0;
        do begin
            rdr(8'h00);
            n++;
        end while (rd[4] !== 1'b1 && n < 20);
        chk(rd[4], 1'b1);
        wr(8'h00, 8'h80);
        wr(8'h00, 8'h04);
        n = 0;
        while (SYS_SOURCE_OUT !== 4'h3 && n < 20) begin
            @(posedge SYS_CLK_IN);
            n++;
        end
        chk(SYS_SOURCE_OUT, 4'h3);
        wr(8'h04, 8'h52);
        wr(8'h00, 8'h80);
        wr(8'h00, 8'h01);
        wr(8'h00, 8'h80);
        wr(8'h00, 8'h05);
        rdr(8'h04);
        chk(rd, 8'h53);
        chk({SRC_ENABLE_OUT, CMD_SOURCE_OUT, CMD_STARTUP_OUT}, 22'h000209);
        $display("switch done");
    endtask
    // Power-down with the detector off, left by a reset wake
    task t_deep;
        wr(8'h0C, 8'h60);
        wr(8'h0C, 8'h40);
        rdr(8'h0C);
        chk(rd[6], 1'b1);
        wr(8'h08, 8'h05);
        SLEEP_INSTR_IN <= 1'b1;
        @(posedge SYS_CLK_IN);
        SLEEP_INSTR_IN <= 1'b0;
        #1;
        chk({SLEEPING_OUT, ADC_START_OUT, CLK_GATES_OUT, BROWNOUT_EN_OUT}, 8'h80);
        @(posedge SYS_CLK_IN);
        RESET_WAKE_IN <= 1'b1;
        @(posedge SYS_CLK_IN);
        RESET_WAKE_IN <= 1'b0;
        #1;
        chk({RESET_VECTOR_OUT, SLEEPING_OUT, BROWNOUT_EN_OUT, RESUME_OUT}, 4'hA);
        @(posedge SYS_CLK_IN);
        $display("deep sleep done");
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge SYS_CLK_IN);
        RESETN_IN <= 1'b1;
        repeat (2) @(posedge SYS_CLK_IN);
        t_regs;
        t_cmds;
        t_switch;
        t_sleep(2'h0, 5'h07);
        t_sleep(2'h1, 5'h03);
        t_deep;
        stop_test;
    end
    // A hung handshake ends the run here
    initial begin
        #100000;
        fails++;
        stop_test;
    end
endmodule
`default_nettype wire

// ===== inc/clksw_defs.svh
// Offsets, field positions, response codes and timing counts for the clock switch block
//
// Behaviour
// - Change-enable updates only when all other command bits are written zero.
// - Change-enable clears after four cycles, or earlier when a command is written.
// - Rewriting change-enable while open neither restarts the window nor clears it.
// - Command register bits 6:5 always read as zero.
// - Ready flag clears on request or enable command; sets once clock is stable.
// - Command 0000 none, 0001 disable, 0010 enable, 0011 request availability.
// - Command 0100 switch, 0101 recover, 0110 watchdog reload, 0111 clock out; 1xxx none.
// - Clock-output bit resets to inverted fuse; recover leaves it alone.
// - Start-up field resets from fuses, feeds enable/disable, survives recover.
// - Source field resets from fuses, feeds enable, disable, request and switch.
// - Recover loads the source field with the source currently driving the clock.
// - Mode 00 is idle: only CPU and flash clocks stop.
// - Mode 01 is ADC noise reduction: I/O, CPU and flash clocks stop.
// - Entering idle or ADC noise reduction with ADC enabled starts a conversion.
// - ADC noise reduction ends only on its limited set of wake sources.
// - Interrupt wake stalls four cycles beyond start-up, then resumes execution.
// - A reset during any sleep wakes the device to the reset vector.
// - With brown-out sleep-off, detector stops at power-down or power-save entry and returns at wake.
// - Wake after brown-out sleep-off takes about 60 us before execution.
// - Brown-out sleep-off resets to zero; writes need a timed enable sequence.
// - Mode 10 is power-down: all generated clocks stop.
// - Mode 11 is power-save: power-down but the asynchronous timer keeps running.
`ifndef CLKSW_DEFS_SVH
`define CLKSW_DEFS_SVH
`define CSR_ADDR 8'h00
`define SEL_ADDR 8'h04
`define SLP_ADDR 8'h08
`define PCR_ADDR 8'h0C
`define STS_ADDR 8'h10
`define CCE_BIT 7
`define CCE_ARM 8'h80
`define CLOCK_OUTPUT_REQUEST_BIT 6
`define BROWNOUT_SLEEP_OFF_BIT 6
`define BODSE_BIT 5
`define SE_BIT 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CCE_WINDOW 4
`define WAKE_STALL 4
`define SUT_CYC0 16'h0004
`define SUT_CYC1 16'h0040
`define SUT_CYC2 16'h0100
`define SUT_CYC3 16'h0400
`define CLK_PERIOD_NS 10
`define BOD_WAKE_US 60
`define BOD_WAKE_CYCLES ((`BOD_WAKE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== inc/clksw_pkg.sv
// Types shared by the clock switch and sleep controller
`default_nettype none
package clksw_pkg;
    typedef enum logic [3:0] {
        CMD_NONE = 4'h0, CMD_DISABLE = 4'h1, CMD_ENABLE = 4'h2, CMD_REQUEST = 4'h3,
        CMD_SWITCH = 4'h4, CMD_RECOVER = 4'h5, CMD_WDT_RELOAD = 4'h6, CMD_CLK_OUT = 4'h7
    } clk_cmd_type;
    typedef enum logic [1:0] {
        MODE_IDLE, MODE_ADC_NR, MODE_POWER_DOWN, MODE_POWER_SAVE
    } sleep_mode_type;
    typedef enum logic [1:0] {SLP_RUN, SLP_ASLEEP, SLP_WAKING} sleep_state_type;
    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic asy;
    } clk_gates_type;
endpackage
`default_nettype wire

// ===== logic/clock_switch_sleep.sv
// Clock command, clock selection and sleep control behind an AXI4-Lite slave
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "clksw_defs.svh"
module clock_switch_sleep import clksw_pkg::*; #(
    parameter int BOD_WAKE_CYCLES = `BOD_WAKE_CYCLES
) (
    input wire logic SYS_CLK_IN, // 100 MHz system clock
    input wire logic RESETN_IN, // Async reset, active low
    input wire logic [7:0] S_AXI_AWADDR_IN, // Write address
    input wire logic S_AXI_AWVALID_IN, // Write address valid
    output logic S_AXI_AWREADY_OUT, // Write address ready
    input wire logic [31:0] S_AXI_WDATA_IN, // Write data
    input wire logic [3:0] S_AXI_WSTRB_IN, // Byte enables
    input wire logic S_AXI_WVALID_IN, // Write data valid
    output logic S_AXI_WREADY_OUT, // Write data ready
    output logic [1:0] S_AXI_BRESP_OUT, // Write response
    output logic S_AXI_BVALID_OUT, // Write response valid
    input wire logic S_AXI_BREADY_IN, // Write response ready
    input wire logic [7:0] S_AXI_ARADDR_IN, // Read address
    input wire logic S_AXI_ARVALID_IN, // Read address valid
    output logic S_AXI_ARREADY_OUT, // Read address ready
    output logic [31:0] S_AXI_RDATA_OUT, // Read data
    output logic [1:0] S_AXI_RRESP_OUT, // Read response
    output logic S_AXI_RVALID_OUT, // Read data valid
    input wire logic S_AXI_RREADY_IN, // Read data ready
    input wire logic CLK_OUT_FUSE_IN, // Clock pin output fuse
    input wire logic [1:0] STARTUP_FUSE_IN, // Start-up time fuses
    input wire logic [3:0] SOURCE_FUSE_IN, // Source select fuses
    input wire logic [15:0] CLK_STABLE_IN, // Per-source stable, async
    input wire logic SLEEP_INSTR_IN, // Sleep instruction pulse
    input wire logic ADC_ENABLED_IN, // ADC is enabled
    input wire logic ADC_DONE_IN, // ADC conversion complete
    input wire logic WAKE_IRQ_IN, // Any enabled interrupt
    input wire logic WAKE_LIMITED_IN, // Noise-reduction wake sources
    input wire logic WAKE_DEEP_IN, // Power-down wake sources
    input wire logic WAKE_TIMER_IN, // Async timer interrupt
    input wire logic RESET_WAKE_IN, // System reset request
    output logic CMD_STROBE_OUT, // Command issued, pulse
    output logic [3:0] CMD_CODE_OUT, // Issued command
    output logic [3:0] CMD_SOURCE_OUT, // Command source code
    output logic [1:0] CMD_STARTUP_OUT, // Command start-up code
    output logic [15:0] SRC_ENABLE_OUT, // Oscillator enables
    output logic [3:0] SYS_SOURCE_OUT, // Source driving system clock
    output logic CLK_PIN_EN_OUT, // Clock output buffer on
    output logic WDT_AUTO_RELOAD_OUT, // Watchdog auto reload mode
    output clk_gates_type CLK_GATES_OUT, // Clock domain enables
    output logic BROWNOUT_EN_OUT, // Brown-out detector on
    output logic ADC_START_OUT, // Start conversion, pulse
    output logic SLEEPING_OUT, // Asleep or waking
    output logic RESUME_OUT, // Wake done, pulse
    output logic RESET_VECTOR_OUT // Restart at reset vector, pulse
);
    // Register select, one-hot: csr, sel, slp, pcr, sts
    function automatic logic [4:0] reg_sel(input logic [7:0] a);
        reg_sel = {a == `STS_ADDR, a == `PCR_ADDR, a == `SLP_ADDR,
                   a == `SEL_ADDR, a == `CSR_ADDR};
    endfunction

    // Upper half of the code space is no command
    function automatic clk_cmd_type decode_cmd(input logic [3:0] v);
        decode_cmd = v[3] ? CMD_NONE : clk_cmd_type'(v);
    endfunction

    function automatic logic deep(input sleep_mode_type m);
        deep = (m == MODE_POWER_DOWN) || (m == MODE_POWER_SAVE);
    endfunction

    // Oscillator restarts only in the deep modes, so only they pay start-up
    function automatic logic [15:0] wake_cycles(input sleep_mode_type m,
                                                input logic [1:0] startup_fuse_bits, input logic brownout_detector);
        logic [15:0] n;
        n = 16'(`WAKE_STALL);
        if (deep(m)) begin
            case (startup_fuse_bits)
                2'h0: n = n + `SUT_CYC0;
                2'h1: n = n + `SUT_CYC1;
                2'h2: n = n + `SUT_CYC2;
                default: n = n + `SUT_CYC3;
            endcase
        end
        if (brownout_detector && n < 16'(BOD_WAKE_CYCLES)) begin
            n = 16'(BOD_WAKE_CYCLES);
        end
        wake_cycles = n;
    endfunction

    function automatic clk_gates_type gates_for(input sleep_state_type s,
                                                input sleep_mode_type m);
        clk_gates_type g;
        g = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, asy: 1'b1};
        if (s != SLP_RUN) begin
            g.cpu = 1'b0;
            g.flash = 1'b0;
            case (m)
                MODE_ADC_NR: g.io = 1'b0;
                MODE_POWER_DOWN: g = '0;
                MODE_POWER_SAVE: g = '{cpu: 1'b0, flash: 1'b0, io: 1'b0,
                                       adc: 1'b0, asy: 1'b1};
                default: g.io = 1'b1;
            endcase
        end
        gates_for = g;
    endfunction

    logic [7:0] waddr;
    logic [7:0] wbyte;
    logic wlane;
    logic cce;
    logic [1:0] cce_cnt;
    logic [3:0] cmd_field;
    logic ready;
    logic clock_output_request;
    logic [1:0] csut;
    logic [3:0] csel;
    logic loaded;
    logic switch_pending;
    logic [3:0] switch_target;
    logic [3:0] watch_code;
    logic se;
    logic [1:0] smode;
    logic brownout_sleep_off;
    logic bodse;
    logic [1:0] bodse_cnt;
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] s3;
    logic [15:0] stable;
    sleep_state_type state;
    sleep_state_type next_state;
    sleep_mode_type run_mode;
    logic bod_off;
    logic [15:0] wake_cnt;

    // Write path decode; a write goes once both address and data are held
    wire wr_go = !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT && !S_AXI_BVALID_OUT;
    wire [4:0] wsel = reg_sel(waddr);
    wire wr_on = wr_go && wlane;
    wire csr_wr = wr_on && wsel[0];
    wire sel_wr = wr_on && wsel[1];
    wire slp_wr = wr_on && wsel[2];
    wire pcr_wr = wr_on && wsel[3];
    wire cce_arm = csr_wr && (wbyte == `CCE_ARM);
    wire cmd_take = csr_wr && cce && !wbyte[`CCE_BIT];
    wire clk_cmd_type cmd = cmd_take ? decode_cmd(wbyte[3:0]) : CMD_NONE;
    wire target_stable = stable[switch_target];
    wire switch_go = switch_pending && target_stable && SRC_ENABLE_OUT[switch_target];

    // Read path decode
    wire [4:0] rsel = reg_sel(S_AXI_ARADDR_IN);
    wire [7:0] csr_rd = {cce, 2'b00, ready, cmd_field};
    wire [7:0] sel_rd = {1'b0, clock_output_request, csut, csel};
    wire [7:0] slp_rd = {5'h00, smode, se};
    wire [7:0] pcr_rd = {1'b0, brownout_sleep_off, bodse, 5'h00};
    wire [7:0] sts_rd = {SYS_SOURCE_OUT, switch_pending, SLEEPING_OUT,
                         WDT_AUTO_RELOAD_OUT, CLK_PIN_EN_OUT};
    wire [7:0] rd_byte = ({8{rsel[0]}} & csr_rd) | ({8{rsel[1]}} & sel_rd) |
                         ({8{rsel[2]}} & slp_rd) | ({8{rsel[3]}} & pcr_rd) |
                         ({8{rsel[4]}} & sts_rd);

    // Write channels: take address and data in either order, answer after both
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            S_AXI_AWREADY_OUT <= 1'b1;
            S_AXI_WREADY_OUT <= 1'b1;
            S_AXI_BVALID_OUT <= 1'b0;
            S_AXI_BRESP_OUT <= `RESP_OKAY;
            waddr <= 8'h00;
            wbyte <= 8'h00;
            wlane <= 1'b0;
        end else begin
            if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
                S_AXI_AWREADY_OUT <= 1'b0;
                waddr <= S_AXI_AWADDR_IN;
            end
            if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
                S_AXI_WREADY_OUT <= 1'b0;
                wbyte <= S_AXI_WDATA_IN[7:0];
                wlane <= S_AXI_WSTRB_IN[0];
            end
            if (wr_go) begin
                S_AXI_BVALID_OUT <= 1'b1;
                S_AXI_BRESP_OUT <= (|wsel[3:0]) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
                S_AXI_BVALID_OUT <= 1'b0;
                S_AXI_AWREADY_OUT <= 1'b1;
                S_AXI_WREADY_OUT <= 1'b1;
            end
        end
    end

    // Read channel: answer one cycle after the address is taken
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            S_AXI_ARREADY_OUT <= 1'b1;
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT <= 32'h00000000;
            S_AXI_RRESP_OUT <= `RESP_OKAY;
        end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            S_AXI_ARREADY_OUT <= 1'b0;
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RDATA_OUT <= {24'h000000, rd_byte};
            S_AXI_RRESP_OUT <= (|rsel) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_ARREADY_OUT <= 1'b1;
        end
    end

    // Change-enable window; a re-arm while open is ignored on purpose
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            cce <= 1'b0;
            cce_cnt <= 2'h0;
            cmd_field <= 4'h0;
        end else if (cmd_take) begin
            cce <= 1'b0;
            cmd_field <= wbyte[3:0];
        end else if (cce_arm && !cce) begin
            cce <= 1'b1;
            cce_cnt <= 2'h0;
        end else if (cce) begin
            cce <= (cce_cnt != 2'(`CCE_WINDOW - 1));
            cce_cnt <= cce_cnt + 2'h1;
        end
    end

    // Stable inputs come from the oscillators: three stages, change on agreement
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            s1 <= 16'h0000;
            s2 <= 16'h0000;
            s3 <= 16'h0000;
            stable <= 16'h0000;
        end else begin
            s1 <= CLK_STABLE_IN;
            s2 <= s1;
            s3 <= s2;
            stable <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & stable);
        end
    end

    // Selection fields load from fuses in the first cycle after reset
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            loaded <= 1'b0;
            clock_output_request <= 1'b0;
            csut <= 2'h0;
            csel <= 4'h0;
        end else if (!loaded) begin
            loaded <= 1'b1;
            clock_output_request <= !CLK_OUT_FUSE_IN;
            csut <= STARTUP_FUSE_IN;
            csel <= SOURCE_FUSE_IN;
        end else if (sel_wr) begin
            clock_output_request <= wbyte[`CLOCK_OUTPUT_REQUEST_BIT];
            csut <= wbyte[5:4];
            csel <= wbyte[3:0];
        end else if (cmd == CMD_RECOVER) begin
            csel <= SYS_SOURCE_OUT;
        end
    end

    // Clock source state; disabling the running source is refused
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            SRC_ENABLE_OUT <= 16'h0000;
            SYS_SOURCE_OUT <= 4'h0;
            switch_pending <= 1'b0;
            switch_target <= 4'h0;
            watch_code <= 4'h0;
            ready <= 1'b0;
            CLK_PIN_EN_OUT <= 1'b0;
            WDT_AUTO_RELOAD_OUT <= 1'b0;
        end else if (!loaded) begin
            SRC_ENABLE_OUT[SOURCE_FUSE_IN] <= 1'b1;
            SYS_SOURCE_OUT <= SOURCE_FUSE_IN;
            switch_target <= SOURCE_FUSE_IN;
            watch_code <= SOURCE_FUSE_IN;
        end else begin
            case (cmd)
                CMD_DISABLE: if (csel != SYS_SOURCE_OUT) SRC_ENABLE_OUT[csel] <= 1'b0;
                CMD_ENABLE: SRC_ENABLE_OUT[csel] <= 1'b1;
                CMD_SWITCH: begin
                    switch_pending <= 1'b1;
                    switch_target <= csel;
                end
                CMD_WDT_RELOAD: WDT_AUTO_RELOAD_OUT <= 1'b1;
                CMD_CLK_OUT: CLK_PIN_EN_OUT <= clock_output_request;
                default: ;
            endcase
            if (cmd == CMD_ENABLE || cmd == CMD_REQUEST) begin
                watch_code <= csel;
                ready <= 1'b0;
            end else begin
                ready <= ready | stable[watch_code];
            end
            if (switch_go && cmd != CMD_SWITCH) begin
                SYS_SOURCE_OUT <= switch_target;
                switch_pending <= 1'b0;
            end
        end
    end

    // Command strobe towards the oscillator control, once per accepted write of a code 0001 to 0111
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            CMD_STROBE_OUT <= 1'b0;
            CMD_CODE_OUT <= 4'h0;
            CMD_SOURCE_OUT <= 4'h0;
            CMD_STARTUP_OUT <= 2'h0;
        end else begin
            CMD_STROBE_OUT <= (cmd != CMD_NONE);
            if (cmd != CMD_NONE) begin
                CMD_CODE_OUT <= cmd;
                CMD_SOURCE_OUT <= csel;
                CMD_STARTUP_OUT <= csut;
            end
        end
    end

    // Sleep control and the timed brown-out sleep-off sequence
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            se <= 1'b0;
            smode <= 2'h0;
            brownout_sleep_off <= 1'b0;
            bodse <= 1'b0;
            bodse_cnt <= 2'h0;
        end else begin
            if (slp_wr) begin
                se <= wbyte[`SE_BIT];
                smode <= wbyte[2:1];
            end
            if (pcr_wr && bodse && !wbyte[`BODSE_BIT]) begin
                brownout_sleep_off <= wbyte[`BROWNOUT_SLEEP_OFF_BIT];
                bodse <= 1'b0;
            end else if (pcr_wr && wbyte[`BODSE_BIT] && wbyte[`BROWNOUT_SLEEP_OFF_BIT] && !bodse) begin
                bodse <= 1'b1;
                bodse_cnt <= 2'h0;
            end else if (bodse) begin
                bodse <= (bodse_cnt != 2'(`CCE_WINDOW - 1));
                bodse_cnt <= bodse_cnt + 2'h1;
            end
        end
    end

    // Wake sources differ per mode; noise reduction listens to few
    wire sleep_mode_type smode_e = sleep_mode_type'(smode);
    wire sleep_mode_type eff_mode = (state == SLP_RUN) ? smode_e : run_mode;
    wire enter = SLEEP_INSTR_IN && se;
    wire wake_hit = (run_mode == MODE_IDLE && WAKE_IRQ_IN) ||
                    (run_mode == MODE_ADC_NR && (ADC_DONE_IN || WAKE_LIMITED_IN)) ||
                    (deep(run_mode) && WAKE_DEEP_IN) ||
                    (run_mode == MODE_POWER_SAVE && WAKE_TIMER_IN);
    wire next_bod_off = (state == SLP_RUN) ? (brownout_sleep_off && deep(smode_e)) : bod_off;

    always_comb begin
        next_state = state;
        case (state)
            SLP_RUN: if (enter) next_state = SLP_ASLEEP;
            SLP_ASLEEP: begin
                if (RESET_WAKE_IN) next_state = SLP_RUN;
                else if (wake_hit) next_state = SLP_WAKING;
            end
            SLP_WAKING: if (RESET_WAKE_IN || wake_cnt == 16'h0000) next_state = SLP_RUN;
            default: next_state = SLP_RUN;
        endcase
    end

    // Sleep state, wake stall count and the registered clock enables
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state <= SLP_RUN;
            run_mode <= MODE_IDLE;
            bod_off <= 1'b0;
            wake_cnt <= 16'h0000;
            CLK_GATES_OUT <= '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, asy: 1'b1};
            BROWNOUT_EN_OUT <= 1'b1;
            ADC_START_OUT <= 1'b0;
            SLEEPING_OUT <= 1'b0;
            RESUME_OUT <= 1'b0;
            RESET_VECTOR_OUT <= 1'b0;
        end else begin
            state <= next_state;
            if (state == SLP_RUN) begin
                run_mode <= smode_e;
                bod_off <= next_bod_off;
            end
            if (state == SLP_ASLEEP) begin
                wake_cnt <= wake_cycles(run_mode, csut, bod_off) - 16'h0001;
            end else if (wake_cnt != 16'h0000) begin
                wake_cnt <= wake_cnt - 16'h0001;
            end
            CLK_GATES_OUT <= gates_for(next_state, eff_mode);
            BROWNOUT_EN_OUT <= !(next_state == SLP_ASLEEP && next_bod_off);
            ADC_START_OUT <= (state == SLP_RUN) && enter && ADC_ENABLED_IN &&
                             !deep(smode_e);
            SLEEPING_OUT <= (next_state != SLP_RUN);
            RESUME_OUT <= (state == SLP_WAKING) && (next_state == SLP_RUN) && !RESET_WAKE_IN;
            RESET_VECTOR_OUT <= (state != SLP_RUN) && RESET_WAKE_IN;
        end
    end

    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    cce_window_a: assert property ($rose(cce) |-> ##[1:4] !cce)
        else $error("change enable held past its window");
    cce_clean_a: assert property ($rose(cce) |-> $past(csr_wr && wbyte == `CCE_ARM))
        else $error("change enable set by an unclean write");
    reserved_zero_a: assert property (S_AXI_RVALID_OUT &&
        $past(rsel[0] && S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) |->
        S_AXI_RDATA_OUT[6:5] == 2'b00)
        else $error("reserved command bits read nonzero");
    cmd_once_a: assert property (CMD_STROBE_OUT |=> !CMD_STROBE_OUT)
        else $error("command strobe repeated");
    ready_clear_a: assert property (cmd == CMD_ENABLE || cmd == CMD_REQUEST |=> !ready)
        else $error("ready not cleared by command");
    recover_a: assert property (cmd == CMD_RECOVER |=> csel == $past(SYS_SOURCE_OUT))
        else $error("recover did not load running source");
    switch_stable_a: assert property ($changed(SYS_SOURCE_OUT) && $past(loaded) |->
        $past(target_stable))
        else $error("switched to an unstable source");
    idle_stall_a: assert property ($rose(state == SLP_WAKING) && run_mode == MODE_IDLE &&
        !bod_off && !RESET_WAKE_IN ##1 !RESET_WAKE_IN [*3] |-> ##1 RESUME_OUT)
        else $error("idle wake stall not four cycles");
    adcnr_gate_a: assert property (state == SLP_ASLEEP && run_mode == MODE_ADC_NR |->
        !CLK_GATES_OUT.io && CLK_GATES_OUT.adc && !CLK_GATES_OUT.cpu)
        else $error("noise reduction clock enables wrong");
    bod_off_a: assert property (state == SLP_ASLEEP && bod_off |-> !BROWNOUT_EN_OUT)
        else $error("brown-out detector left on in sleep");
endmodule
`default_nettype wire
